// ===== hdl/pdsc_defs.svh
`ifndef PDSC_DEFS_SVH
`define PDSC_DEFS_SVH

// ==========================================================
// Register byte offsets
`define PDSC_OFF_CTRL 8'h00
`define PDSC_OFF_STATUS 8'h04
`define PDSC_OFF_CFG 8'h08
`define PDSC_OFF_STRAP 8'h0C

// ==========================================================
// Control register bits
`define PDSC_CTRL_PD 0
`define PDSC_CTRL_EDPD 1
`define PDSC_CTRL_SRST 2
`define PDSC_CTRL_MASK 3

// ==========================================================
// Status register bits
`define PDSC_ST_FLAG 0
`define PDSC_ST_IRQSRC 1
`define PDSC_ST_DOWN 2
`define PDSC_ST_HPD 3
`define PDSC_ST_CORERST 4
`define PDSC_ST_PLLLOST 5

// ==========================================================
// Configuration register fields
`define PDSC_CFG_ADDR_LSB 0
`define PDSC_CFG_DLY_LSB 8
`define PDSC_CFG_PAUSE 10
`define PDSC_CFG_MODE_LSB 11
`define PDSC_MODE_BASE 5'h17
`define PDSC_DLY_OFF 2'h0
`define PDSC_DLY_ON 2'h3
`define PDSC_CODE_MODE_PIN3 2'h2

// ==========================================================
// Bus answers
`define PDSC_RESP_OKAY 2'h0
`define PDSC_RESP_SLVERR 2'h2

// ==========================================================
// Timing
`define PDSC_CLK_MHZ 10
`define PDSC_PD_RESET_US 256
`define PDSC_PD_RESET_CYC (`PDSC_PD_RESET_US * `PDSC_CLK_MHZ)
`define PDSC_SETTLE_NS 1000
`define PDSC_SETTLE_CYC ((`PDSC_SETTLE_NS * `PDSC_CLK_MHZ + 999) / 1000)

`endif

// ===== hdl/pdsc_pkg.sv
// ==========================================================
// Shared types
package pdsc_pkg;

    // Configuration capture sequence
    typedef enum logic [2:0] {
        LATCH_PROBE_A = 3'b001,
        LATCH_PROBE_B = 3'b010,
        LATCH_RUN = 3'b100
    } pdsc_latch_state_type;

    // Power state of the transceiver core
    typedef enum logic [3:0] {
        PW_ACTIVE = 4'b0001,
        PW_DOWN = 4'b0010,
        PW_SLEEP = 4'b0100,
        PW_WAKE_RST = 4'b1000
    } pdsc_power_state_type;

endpackage : pdsc_pkg

// ===== hdl/pdsc_level_decode.sv
`timescale 1ns/1ns

// ==========================================================
// Four-level pin decoder: two samples taken under opposite
// LED probe patterns tell ground, LED100, LED1000 and supply apart
module pdsc_level_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic cap_a,
    input wire logic cap_b,
    output logic [1:0] code_q
);

    logic sample_a_q; // Level seen with LED100 high
    logic sample_a_d;
    logic [1:0] code_d;

    // ======================================================
    // Next values
    always_comb
    begin
        sample_a_d = cap_a ? pin : sample_a_q;
        // Follows LED1000 -> bit1, follows LED100 -> bit0
        code_d = cap_b ? {pin, sample_a_q} : code_q;
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sample_a_q <= 1'b0;
            code_q <= 2'h0;
        end
        else
        begin
            sample_a_q <= sample_a_d;
            code_q <= code_d;
        end
    end

endmodule : pdsc_level_decode

// ===== hdl/pdsc_top.sv
`timescale 1ns/1ns
`include "pdsc_defs.svh"
// ==========================================================
// Function
// - General power-down keeps only management alive
// - Clearing power-down applies power-down reset
// - Energy-detect sleep silences transmit without energy
// - Line energy sets flag and wakes core
// - Flag with mask enabled raises interrupt
// - First wake packets may be dropped
// - Pin power-down; strap picks PLL state
// - Pin held at reset powers down once capture completes
// - Straps tri-stated in reset, then latched
// - Delay strap sets delay bits 00/11
// - Latch four config pins after reset
// - Pins decode to four level codes
// - Address from pin0 code and pin1
// - Pin1 upper codes set pause
// - Addresses above seven only by write
// - Pins three and two set mode
// - Mode loads base plus pin2 code when pin3 code is 2
// - Soft reset keeps registers, no relatch
// - Power-down reset held 256 microseconds
module pdsc_top #(
    parameter int ADDR_W = 8,
    parameter int TMR_W = 12,
    parameter int PD_RESET_CYC = `PDSC_PD_RESET_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and core controls
    input wire logic hw_powerdown_pin,
    input wire logic line_detect_a,
    input wire logic [3:0] cfg_pin,
    output logic probe_active,
    output logic probe_100_led,
    output logic probe_1000_led,
    input wire logic [1:0] strap_in,
    input wire logic [1:0] strap_func,
    output logic [1:0] strap_out,
    output logic [1:0] strap_oe_n,
    output logic core_power_on,
    output logic core_reset,
    output logic pll_enable,
    output logic tx_enable,
    output logic rx_accept,
    output logic line_energy_flag,
    output logic energy_irq,
    output logic [4:0] mgmt_address_field,
    output logic pause_adv,
    output logic [1:0] clk_delay_en,
    output logic [4:0] operating_mode_field
);

    // ======================================================
    // Synchroniser and configuration capture
    logic hpd_meta_q; // First stage, read only by second stage
    logic hpd_s_q; // Synchronised power-down pin
    pdsc_pkg::pdsc_latch_state_type latch_q, latch_d;
    logic [3:0] settle_q, settle_d; // Probe settle count
    logic cfg_load_q, cfg_load_d; // Codes ready, load registers
    logic [1:0] strap_lat_q, strap_lat_d; // 0: PLL select, 1: delay
    logic [1:0] strap_out_q;
    logic cap_a;
    logic cap_b;
    logic [1:0] code [4];
    logic running;

    // Synchroniser is not reset so a pin held during reset is
    // already visible at release
    always_ff @(posedge clk)
    begin
        hpd_meta_q <= hw_powerdown_pin;
        hpd_s_q <= hpd_meta_q;
    end

    // Capture sequencing: probe pattern A, pattern B, then run
    always_comb
    begin
        latch_d = latch_q;
        settle_d = settle_q;
        cap_a = 1'b0;
        cap_b = 1'b0;
        strap_lat_d = strap_lat_q;
        unique case (latch_q)
            pdsc_pkg::LATCH_PROBE_A:
            begin
                if (settle_q == 4'h0)
                begin
                    cap_a = 1'b1;
                    // Straps are still tri-stated, pulls decide
                    strap_lat_d = strap_in;
                    settle_d = 4'(`PDSC_SETTLE_CYC - 1);
                    latch_d = pdsc_pkg::LATCH_PROBE_B;
                end
                else
                    settle_d = settle_q - 4'h1;
            end
            pdsc_pkg::LATCH_PROBE_B:
            begin
                if (settle_q == 4'h0)
                begin
                    cap_b = 1'b1;
                    latch_d = pdsc_pkg::LATCH_RUN;
                end
                else
                    settle_d = settle_q - 4'h1;
            end
            pdsc_pkg::LATCH_RUN:
            begin
                // Only a hardware reset relatches
                latch_d = pdsc_pkg::LATCH_RUN;
            end
        endcase
        cfg_load_d = cap_b;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            latch_q <= pdsc_pkg::LATCH_PROBE_A;
            settle_q <= 4'(`PDSC_SETTLE_CYC - 1);
            cfg_load_q <= 1'b0;
            strap_lat_q <= 2'h0;
            strap_out_q <= 2'h0;
        end
        else
        begin
            latch_q <= latch_d;
            settle_q <= settle_d;
            cfg_load_q <= cfg_load_d;
            strap_lat_q <= strap_lat_d;
            strap_out_q <= strap_func;
        end
    end

    // One decoder per configuration pin
    for (genvar i = 0; i < 4; i++)
    begin : g_dec
        pdsc_level_decode u_dec (
            .clk(clk),
            .rst_n(rst_n),
            .pin(cfg_pin[i]),
            .cap_a(cap_a),
            .cap_b(cap_b),
            .code_q(code[i])
        );
    end

    assign running = (latch_q == pdsc_pkg::LATCH_RUN) && !cfg_load_q;
    assign probe_active = (latch_q != pdsc_pkg::LATCH_RUN);
    assign probe_100_led = (latch_q == pdsc_pkg::LATCH_PROBE_A);
    assign probe_1000_led = (latch_q == pdsc_pkg::LATCH_PROBE_B);
    // Straps float in reset and capture, driven afterwards
    assign strap_oe_n = {2{probe_active}};
    assign strap_out = strap_out_q;

    // ======================================================
    // Power state
    pdsc_pkg::pdsc_power_state_type pw_q, pw_d;
    logic [TMR_W-1:0] pdr_q, pdr_d; // Power-down reset timer
    logic [TMR_W-1:0] srst_q, srst_d; // Soft reset timer
    logic pll_lost_q, pll_lost_d;
    logic flag_q, flag_d;
    logic irq_src_q, irq_src_d;
    logic rx_ok_q, rx_ok_d;
    logic pd_bit_q; // Control register bits
    logic edpd_q;
    logic mask_q;
    logic pd_req;
    logic srst_start;
    logic rd_status;

    assign pd_req = pd_bit_q || hpd_s_q;

    // Power transitions, held until capture completes
    always_comb
    begin
        pw_d = pw_q;
        pdr_d = pdr_q;
        unique case (pw_q)
            pdsc_pkg::PW_ACTIVE:
            begin
                if (running && pd_req)
                    pw_d = pdsc_pkg::PW_DOWN;
                else if (running && edpd_q && !line_detect_a)
                    pw_d = pdsc_pkg::PW_SLEEP;
            end
            pdsc_pkg::PW_DOWN:
            begin
                if (!pd_req)
                begin
                    pw_d = pdsc_pkg::PW_WAKE_RST;
                    pdr_d = TMR_W'(PD_RESET_CYC - 1);
                end
            end
            pdsc_pkg::PW_SLEEP:
            begin
                if (pd_req)
                    pw_d = pdsc_pkg::PW_DOWN;
                // Resume prior state directly, no reset
                else if (line_detect_a || !edpd_q)
                    pw_d = pdsc_pkg::PW_ACTIVE;
            end
            pdsc_pkg::PW_WAKE_RST:
            begin
                if (pd_req)
                    pw_d = pdsc_pkg::PW_DOWN;
                else if (pdr_q == '0)
                    pw_d = pdsc_pkg::PW_ACTIVE;
                else
                    pdr_d = pdr_q - TMR_W'(1);
            end
        endcase
        // Soft reset self-clears after PD_RESET_CYC - 1 cycles, one short of the power-down reset period
        if (srst_start)
            srst_d = TMR_W'(PD_RESET_CYC - 1);
        else if (srst_q != '0)
            srst_d = srst_q - TMR_W'(1);
        else
            srst_d = srst_q;
        // PLL stays off until a soft reset; a shutdown wins a tie
        if (pw_q == pdsc_pkg::PW_DOWN && hpd_s_q && !strap_lat_q[0])
            pll_lost_d = 1'b1;
        else if (srst_start)
            pll_lost_d = 1'b0;
        else
            pll_lost_d = pll_lost_q;
        flag_d = line_detect_a;
        // Rising flag sets the source; set beats a read clear
        if (flag_d && !flag_q)
            irq_src_d = 1'b1;
        else if (rd_status)
            irq_src_d = 1'b0;
        else
            irq_src_d = irq_src_q;
        // Receive opens one cycle after wake: a packet that
        // caused the wake is lost
        rx_ok_d = (pw_q == pdsc_pkg::PW_ACTIVE);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pw_q <= pdsc_pkg::PW_ACTIVE;
            pdr_q <= '0;
            srst_q <= '0;
            pll_lost_q <= 1'b0;
            flag_q <= 1'b0;
            irq_src_q <= 1'b0;
            rx_ok_q <= 1'b0;
        end
        else
        begin
            pw_q <= pw_d;
            pdr_q <= pdr_d;
            srst_q <= srst_d;
            pll_lost_q <= pll_lost_d;
            flag_q <= flag_d;
            irq_src_q <= irq_src_d;
            rx_ok_q <= rx_ok_d;
        end
    end

    assign core_power_on = (pw_q == pdsc_pkg::PW_ACTIVE)
        || (pw_q == pdsc_pkg::PW_WAKE_RST);
    assign core_reset = (pw_q == pdsc_pkg::PW_WAKE_RST)
        || (srst_q != '0) || pll_lost_q;
    assign pll_enable = !pll_lost_q;
    assign tx_enable = (pw_q == pdsc_pkg::PW_ACTIVE) && !core_reset;
    assign rx_accept = rx_ok_q && tx_enable;
    assign line_energy_flag = flag_q;
    assign energy_irq = irq_src_q && mask_q;

    // ======================================================
    // Register file and AXI4-Lite slave
    logic pd_bit_d, edpd_d, mask_d;
    logic [4:0] addr_q, addr_d;
    logic [1:0] dly_q, dly_d;
    logic pause_q, pause_d;
    logic [4:0] mode_q, mode_d; // Readable, rewritable field
    logic [4:0] mode_app_q, mode_app_d; // Mode in effect
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [ADDR_W-1:0] awa_q, awa_d;
    logic [15:0] wd_q, wd_d;
    logic [1:0] ws_q, ws_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] wmask;
    logic [15:0] wval;
    logic [15:0] cur;
    logic do_wr;
    logic rd_take;
    logic [7:0] wa;
    logic [7:0] ra;

    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !w_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign do_wr = aw_q && w_q && !bv_q;
    assign rd_take = s_axi_arvalid && !rv_q;
    assign wa = 8'({awa_q[ADDR_W-1:2], 2'b00});
    assign ra = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
    assign rd_status = rd_take && (ra == `PDSC_OFF_STATUS);
    assign wmask = {{8{ws_q[1]}}, {8{ws_q[0]}}};
    assign srst_start = do_wr && (wa == `PDSC_OFF_CTRL) && ws_q[0]
        && wd_q[`PDSC_CTRL_SRST];

    // Bus handshakes, register writes and read data
    always_comb
    begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        bresp_d = bresp_q;
        rv_d = rv_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        edpd_d = edpd_q;
        mask_d = mask_q;
        addr_d = addr_q;
        dly_d = dly_q;
        pause_d = pause_q;
        mode_d = mode_q;
        mode_app_d = mode_app_q;
        cur = 16'h0000;
        // Address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_d = 1'b1;
            wd_d = s_axi_wdata[15:0];
            ws_d = s_axi_wstrb[1:0];
        end
        // Configuration from pin codes after hardware reset only
        if (cfg_load_q)
        begin
            addr_d = {2'h0, code[1][0], code[0]};
            pause_d = code[1][1];
            dly_d = strap_lat_q[1] ? `PDSC_DLY_ON : `PDSC_DLY_OFF;
            mode_d = (code[3] == `PDSC_CODE_MODE_PIN3)
                ? `PDSC_MODE_BASE + 5'(code[2]) : `PDSC_MODE_BASE;
            mode_app_d = mode_d;
        end
        if (do_wr)
        begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            bresp_d = `PDSC_RESP_OKAY;
            unique case (wa)
                `PDSC_OFF_CTRL:
                begin
                    cur = {12'h000, mask_q, 1'b0, edpd_q, pd_bit_q};
                    wval = (cur & ~wmask) | (wd_q & wmask);
                    edpd_d = wval[`PDSC_CTRL_EDPD];
                    mask_d = wval[`PDSC_CTRL_MASK];
                end
                `PDSC_OFF_CFG:
                begin
                    cur = {mode_q, pause_q, dly_q, 3'h0, addr_q};
                    wval = (cur & ~wmask) | (wd_q & wmask);
                    // Any address, also above seven, by write
                    addr_d = wval[`PDSC_CFG_ADDR_LSB +: 5];
                    dly_d = wval[`PDSC_CFG_DLY_LSB +: 2];
                    pause_d = wval[`PDSC_CFG_PAUSE];
                    // Stored only; the applied mode is not changed
                    mode_d = wval[`PDSC_CFG_MODE_LSB +: 5];
                end
                `PDSC_OFF_STATUS, `PDSC_OFF_STRAP:
                    wval = 16'h0000; // Read-only, write ignored
                default:
                begin
                    wval = 16'h0000;
                    bresp_d = `PDSC_RESP_SLVERR;
                end
            endcase
        end
        else
            wval = 16'h0000;
        if (bv_q && s_axi_bready)
            bv_d = 1'b0;
        if (rv_q && s_axi_rready)
            rv_d = 1'b0;
        // Management answers in every power state
        if (rd_take)
        begin
            rv_d = 1'b1;
            rresp_d = `PDSC_RESP_OKAY;
            unique case (ra)
                `PDSC_OFF_CTRL:
                    rdata_d = {28'h0000000, mask_q, srst_q != '0,
                        edpd_q, pd_bit_q};
                `PDSC_OFF_STATUS:
                    rdata_d = {26'h0000000, pll_lost_q, core_reset,
                        hpd_s_q, !core_power_on, irq_src_q, flag_q};
                `PDSC_OFF_CFG:
                    rdata_d = {16'h0000, mode_q, pause_q, dly_q, 3'h0,
                        addr_q};
                `PDSC_OFF_STRAP:
                    rdata_d = {22'h000000, code[3], code[2], code[1],
                        code[0], strap_lat_q};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = `PDSC_RESP_SLVERR;
                end
            endcase
        end
        // Pin forces the bit; software clears it after the pin drops
        if (hpd_s_q)
            pd_bit_d = 1'b1;
        else if (do_wr && wa == `PDSC_OFF_CTRL && ws_q[0])
            pd_bit_d = wd_q[`PDSC_CTRL_PD];
        else
            pd_bit_d = pd_bit_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= '0;
            wd_q <= 16'h0000;
            ws_q <= 2'h0;
            bv_q <= 1'b0;
            bresp_q <= `PDSC_RESP_OKAY;
            rv_q <= 1'b0;
            rresp_q <= `PDSC_RESP_OKAY;
            rdata_q <= 32'h00000000;
            pd_bit_q <= 1'b0;
            edpd_q <= 1'b0;
            mask_q <= 1'b0;
            addr_q <= 5'h00;
            dly_q <= `PDSC_DLY_OFF;
            pause_q <= 1'b0;
            mode_q <= `PDSC_MODE_BASE;
            mode_app_q <= `PDSC_MODE_BASE;
        end
        else
        begin
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            bresp_q <= bresp_d;
            rv_q <= rv_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            pd_bit_q <= pd_bit_d;
            edpd_q <= edpd_d;
            mask_q <= mask_d;
            addr_q <= addr_d;
            dly_q <= dly_d;
            pause_q <= pause_d;
            mode_q <= mode_d;
            mode_app_q <= mode_app_d;
        end
    end

    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign mgmt_address_field = addr_q;
    assign pause_adv = pause_q;
    assign clk_delay_en = dly_q;
    assign operating_mode_field = mode_app_q;

endmodule : pdsc_top

// ===== verif/pdsc_top_asserts.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks of the power-down and strap block
module pdsc_top_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_detect_a,
    input wire logic probe_active,
    input wire logic [1:0] strap_func,
    input wire logic [1:0] strap_out,
    input wire logic [1:0] strap_oe_n,
    input wire logic core_power_on,
    input wire logic core_reset,
    input wire logic pll_enable,
    input wire logic tx_enable,
    input wire logic rx_accept,
    input wire logic line_energy_flag,
    input wire logic [4:0] operating_mode_field
);
    // One clock domain, checks idle during hardware reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Sampled reset guards the release edge, where the flag is still clear
    AST_FLAG: assert property (rst_n && line_detect_a |=> line_energy_flag)
        else $error("energy flag missed line energy");
    AST_QUIET: assert property (!core_power_on |-> !tx_enable && !rx_accept)
        else $error("powered-down core still passes data");
    // Eight cycles is far below any legal hold, so no false alarm
    AST_PDHOLD: assert property ($rose(core_reset) |-> core_reset [*8])
        else $error("power-down reset released too early");
    AST_PLL: assert property (!pll_enable |-> core_reset)
        else $error("core runs with the PLL stopped");
    AST_TRI: assert property (probe_active |-> strap_oe_n == 2'h3)
        else $error("strap driven during capture");
    AST_SOUT: assert property (strap_oe_n == 2'h0 |-> strap_out == $past(strap_func))
        else $error("strap output not the function value");
    AST_MODE: assert property (!probe_active [*4] |-> $stable(operating_mode_field))
        else $error("mode field changed after capture");
    AST_RX: assert property (rx_accept |-> tx_enable && $past(core_power_on))
        else $error("receive opened before the core woke");
endmodule : pdsc_top_asserts

bind pdsc_top pdsc_top_asserts u_chk (.*);

// ===== verif/pdsc_pins_model.sv
`timescale 1ns/1ns
// ==========================================================
// Board wiring: four-level pins and resistor-only straps
module pdsc_pins_model (
    input wire logic [7:0] codes,
    input wire logic [1:0] pulls,
    input wire logic probe_100_led,
    input wire logic probe_1000_led,
    input wire logic [1:0] strap_oe_n,
    input wire logic [1:0] strap_out,
    output logic [3:0] cfg_pin,
    output logic [1:0] strap_in
);
    // Pin i tied to ground, an LED line or supply
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            case (codes[2*i+:2])
                2'h0: cfg_pin[i] = 1'h0;
                2'h1: cfg_pin[i] = probe_100_led;
                2'h2: cfg_pin[i] = probe_1000_led;
                default: cfg_pin[i] = 1'h1;
            endcase
        end
    end
    // Released straps fall to their resistor, never driven in
    assign strap_in = (pulls & strap_oe_n) | (strap_out & ~strap_oe_n);
endmodule : pdsc_pins_model

// ===== verif/test_powerdown_and_strap_config.sv
`timescale 1ns/1ns
// ==========================================================
// Bench: wiring rows first, then power-down sequences
module test_powerdown_and_strap_config;
    localparam int PDC = 20; // Short power-down reset for speed
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, codes = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF; // Whole words only
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic hw_powerdown_pin = 1'h0, line_detect_a = 1'h1;
    logic [1:0] strap_func = 2'h0, pulls = 2'h0, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, probe_active, probe_100_led, probe_1000_led;
    logic core_power_on, core_reset, pll_enable, tx_enable, rx_accept;
    logic line_energy_flag, energy_irq, pause_adv;
    logic [1:0] s_axi_bresp, s_axi_rresp, strap_in, strap_out, strap_oe_n;
    logic [1:0] clk_delay_en;
    logic [3:0] cfg_pin;
    logic [4:0] mgmt_address_field, operating_mode_field;
    int err_total = 0, checked = 0;
    // Codes pin3..0, pulls, then address, pause, mode, delay bits
    logic [22:0] rows [6] = '{{8'h80, 2'h0, 5'h00, 1'h0, 5'h17, 2'h0},
        {8'h95, 2'h2, 5'h05, 1'h0, 5'h18, 2'h3},
        {8'hAA, 2'h1, 5'h02, 1'h1, 5'h19, 2'h0},
        {8'hBF, 2'h3, 5'h07, 1'h1, 5'h1A, 2'h3},
        {8'hC3, 2'h0, 5'h03, 1'h0, 5'h17, 2'h0},
        {8'h2C, 2'h0, 5'h04, 1'h1, 5'h17, 2'h0}};
    // Every bench signal carries the name of the port it meets
    pdsc_top #(.PD_RESET_CYC(PDC)) u_dut (.*);
    pdsc_pins_model u_pins (.*);
    always #50 clk = ~clk; // 10 MHz
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Six reset cycles, then room for capture
    task automatic hwrst();
        rst_n <= 1'h0;
        repeat (6) @(posedge clk);
        chk(strap_oe_n, 2'h3);
        rst_n <= 1'h1;
        repeat (40) @(posedge clk);
    endtask : hwrst
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask : rdr
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // ==========================================================
    // Main sequence
    initial
    begin
        foreach (rows[i])
        begin
            @(posedge clk);
            codes <= rows[i][22:15];
            pulls <= rows[i][14:13];
            strap_func <= rows[i][14:13];
            hwrst();
            chk(mgmt_address_field, rows[i][12:8]);
            chk(pause_adv, rows[i][7]);
            chk(operating_mode_field, rows[i][6:2]);
            chk(clk_delay_en, rows[i][1:0]);
            chk(strap_out, rows[i][14:13]);
            $display("row %0d done", i);
        end
        wr(8'h00, 32'h1);
        repeat (3) @(posedge clk);
        chk({core_power_on, tx_enable}, 2'h0);
        rdr(8'h04);
        chk(rd[2], 1'h1);
        wr(8'h00, 32'h0);
        repeat (2) @(posedge clk);
        chk({core_power_on, core_reset}, 2'h3);
        repeat (PDC + 4) @(posedge clk);
        chk({core_reset, tx_enable}, 2'h1);
        $display("general power-down done");
        line_detect_a <= 1'h0;
        wr(8'h00, 32'hA);
        repeat (3) @(posedge clk);
        chk({core_power_on, tx_enable}, 2'h0);
        line_detect_a <= 1'h1;
        repeat (3) @(posedge clk);
        chk({line_energy_flag, energy_irq, core_power_on}, 3'h7);
        chk({core_reset, rx_accept}, 2'h1);
        rdr(8'h04);
        @(posedge clk);
        chk(energy_irq, 1'h0);
        wr(8'h00, 32'h2);
        line_detect_a <= 1'h0;
        repeat (3) @(posedge clk);
        line_detect_a <= 1'h1;
        repeat (3) @(posedge clk);
        chk(energy_irq, 1'h0);
        $display("energy detect done");
        hw_powerdown_pin <= 1'h1;
        repeat (10) @(posedge clk);
        chk({core_power_on, pll_enable}, 2'h0);
        hw_powerdown_pin <= 1'h0;
        repeat (3) @(posedge clk);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'hF81F);
        wr(8'h00, 32'h4);
        for (int n = 0; n < 3000 && core_reset !== 1'h0; n++)
            @(posedge clk);
        chk({pll_enable, mgmt_address_field}, 6'h3F);
        chk(operating_mode_field, 5'h17);
        wr(8'h10, 32'h1);
        chk(rsp, 2'h2);
        hw_powerdown_pin <= 1'h1;
        hwrst();
        chk(core_power_on, 1'h0);
        $display("hardware power-down done");
        summarize();
    end
    // Watchdog: the run needs about 450 cycles
    initial
    begin
        repeat (10000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule : test_powerdown_and_strap_config
